// File: logic/sps_host.sv
`include "sps_regs.svh"

module sps_host #(
    parameter int HOLD_CYCLES = `SPS_MS_TO_CYC(`SPS_T_LOW_MIN_MS),
    parameter int READY_CYCLES = `SPS_MS_TO_CYC(`SPS_T_READY_MAX_MS)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    sps_link_if.host link,
    input wire logic power_on,
    input wire logic user_tx,
    input wire logic user_grant_n,
    input wire logic user_audio_clk,
    input wire logic user_audio_fsync,
    input wire logic user_audio_in,
    output logic host_ready,
    output logic host_fail,
    output logic user_rx,
    output logic dev_flow_req
);

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int CW = sps_pkg::CNT_W;
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);
    localparam logic [CW-1:0] READY_LAST = CW'(READY_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [3:0] STAT_OFF = 4'h0;
    localparam logic [3:0] STAT_SUP = 4'h3;
    localparam logic [3:0] STAT_ALL = 4'hF;

    // Reset: request driven low, supplies off
    localparam sps_pkg::sps_host_t HST_RST = '{
        st: sps_pkg::SPS_HST_OFF,
        cnt: '0,
        s1: '1, // Pulled-up idle levels, no false ready
        s2: '1,
        out: '0,
        oe_n: ~`SPS_HOST_DRV_OFF,
        stat: 4'h0,
        ready: 1'b0,
        fail: 1'b0
    };

    sps_pkg::sps_host_t h_reg;
    sps_pkg::sps_host_t h_next;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        h_next = h_reg;
        h_next.s1 = {link.level[`SPS_PIN_SOUT], link.level[`SPS_PIN_FREQ]};
        h_next.s2 = h_reg.s1;
        h_next.out = '0;
        h_next.out[`SPS_PIN_SIN] = 1'b1;
        h_next.out[`SPS_PIN_FGNT] = 1'b1;
        h_next.ready = 1'b0;
        h_next.fail = 1'b0;
        if (!power_on) begin
            // Request low first; drive nothing else
            h_next.st = sps_pkg::SPS_HST_OFF;
            h_next.cnt = CNT_ZERO;
            h_next.stat = STAT_OFF;
            h_next.out = '0;
            h_next.oe_n = ~`SPS_HOST_DRV_OFF;
        end else begin
            case (h_reg.st)
                sps_pkg::SPS_HST_OFF: begin
                    // Supplies on, request held low
                    h_next.st = sps_pkg::SPS_HST_HOLD;
                    h_next.cnt = CNT_ZERO;
                    h_next.stat = STAT_SUP;
                    h_next.oe_n = ~`SPS_HOST_DRV_BOOT;
                end
                sps_pkg::SPS_HST_HOLD: begin
                    // Minimum low time, supplies settle meanwhile
                    h_next.oe_n = ~`SPS_HOST_DRV_BOOT;
                    if (h_reg.cnt == HOLD_LAST) begin
                        h_next.st = sps_pkg::SPS_HST_WAIT;
                        h_next.cnt = CNT_ZERO;
                        h_next.stat = STAT_ALL;
                        h_next.out[`SPS_PIN_PDR] = 1'b1;
                    end else begin
                        h_next.cnt = h_reg.cnt + CNT_ONE;
                    end
                end
                sps_pkg::SPS_HST_WAIT: begin
                    // Released; wait for flow request low
                    h_next.oe_n = ~`SPS_HOST_DRV_BOOT;
                    h_next.out[`SPS_PIN_PDR] = 1'b1;
                    if (!h_reg.s2[0]) begin
                        h_next.st = sps_pkg::SPS_HST_READY;
                        h_next.ready = 1'b1;
                        h_next.oe_n = ~`SPS_HOST_DRV_RUN;
                    end else if (h_reg.cnt == READY_LAST) begin
                        h_next.st = sps_pkg::SPS_HST_FAIL;
                        h_next.fail = 1'b1;
                        h_next.out[`SPS_PIN_PDR] = 1'b0;
                    end else begin
                        h_next.cnt = h_reg.cnt + CNT_ONE;
                    end
                end
                sps_pkg::SPS_HST_READY: begin
                    // Traffic only after ready seen
                    h_next.ready = 1'b1;
                    h_next.oe_n = ~`SPS_HOST_DRV_RUN;
                    h_next.out[`SPS_PIN_PDR] = 1'b1;
                    h_next.out[`SPS_PIN_SIN] = user_tx;
                    h_next.out[`SPS_PIN_FGNT] = user_grant_n;
                    h_next.out[`SPS_PIN_ACLK] = user_audio_clk;
                    h_next.out[`SPS_PIN_AFS] = user_audio_fsync;
                    h_next.out[`SPS_PIN_AIN] = user_audio_in;
                end
                sps_pkg::SPS_HST_FAIL: begin
                    // Device not up; held in shutdown until power_on drops
                    h_next.fail = 1'b1;
                    h_next.oe_n = ~`SPS_HOST_DRV_BOOT;
                end
                default: begin
                    h_next.st = sps_pkg::SPS_HST_OFF;
                    h_next.cnt = CNT_ZERO;
                    h_next.stat = STAT_OFF;
                    h_next.out = '0;
                    h_next.oe_n = ~`SPS_HOST_DRV_OFF;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            h_reg <= HST_RST;
        end else if (ce) begin
            h_reg <= h_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.host_out = h_reg.out;
    assign link.host_oe_n = h_reg.oe_n;
    assign link.stat = h_reg.stat;
    assign host_ready = h_reg.ready;
    assign host_fail = h_reg.fail;
    assign user_rx = h_reg.s2[1];
    assign dev_flow_req = h_reg.s2[0];

endmodule

// File: logic/sps_regs.svh
// Functional notes
// - Host holds power-down request low at start
// - Host releases request only after supplies stable
// - Fast clock stable within 20 ms of release
// - Slow clock stable within 2 ms of release
// - Device drives flow request low within 100 ms
// - No flow request low means not powered up
// - Request low: ultra-low power, internal reset
// - Host holds request low at least 5 ms
// - Shutdown and power-up: pins Hi-Z, pulls on
// - Active only with both supplies, request released
// - Host drives no pins without I/O supply; host still drives the request pin low
// - I/O supply, request asserted: three-state, pulls on
// - Active default: serial out, flow request high
// - Shutdown: host pins pulled up, audio down
// - Internal pull-down keeps request input low
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SPS_CLK_HZ 10000000
`define SPS_CYC_PER_MS (`SPS_CLK_HZ / 1000)
`define SPS_T_FAST_CLK_MS 20
`define SPS_T_SLOW_CLK_MS 2
`define SPS_T_READY_MAX_MS 100
`define SPS_T_LOW_MIN_MS 5
`define SPS_MS_TO_CYC(ms) ((ms) * `SPS_CYC_PER_MS)

// ****************************************************************
// Pin indices on the link
// ****************************************************************
`define SPS_NPIN 10
`define SPS_PIN_SIN 0
`define SPS_PIN_SOUT 1
`define SPS_PIN_FREQ 2
`define SPS_PIN_FGNT 3
`define SPS_PIN_ACLK 4
`define SPS_PIN_AFS 5
`define SPS_PIN_AIN 6
`define SPS_PIN_AOUT 7
`define SPS_PIN_DBG 8
`define SPS_PIN_PDR 9

// ****************************************************************
// Pad masks per power mode
// ****************************************************************
`define SPS_PU_SHUT 10'h10F
`define SPS_PD_SHUT 10'h2F0
`define SPS_PU_ACT 10'h009
`define SPS_PD_ACT 10'h2F0
`define SPS_DRV_ACT 10'h106
`define SPS_DRV_NONE 10'h000
`define SPS_HOST_DRV_BOOT 10'h208
`define SPS_HOST_DRV_RUN 10'h279
`define SPS_HOST_DRV_OFF 10'h200

// ****************************************************************
// Status inputs to the device
// ****************************************************************
`define SPS_NSTAT 4
`define SPS_ST_MAIN 0
`define SPS_ST_IO 1
`define SPS_ST_FAST 2
`define SPS_ST_SLOW 3

`endif

// File: logic/sps_pkg.sv
package sps_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    localparam int CNT_W = 24;

    // Device power state, Gray along power-up path
    typedef enum logic [1:0] {
        SPS_DEV_SHUT = 2'h0,
        SPS_DEV_BOOT = 2'h1,
        SPS_DEV_INIT = 2'h3,
        SPS_DEV_READY = 2'h2
    } sps_dev_state_t;

    // Host sequencer state, Gray along power-up path
    typedef enum logic [2:0] {
        SPS_HST_OFF = 3'h0,
        SPS_HST_HOLD = 3'h1,
        SPS_HST_WAIT = 3'h3,
        SPS_HST_READY = 3'h2,
        SPS_HST_FAIL = 3'h6
    } sps_host_state_t;

    // Device state
    typedef struct packed {
        sps_dev_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [13:0] s1;
        logic [13:0] s2;
        logic [9:0] out;
        logic [9:0] oe_n;
        logic [9:0] pu;
        logic [9:0] pd;
    } sps_dev_t;

    // Host state
    typedef struct packed {
        sps_host_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [9:0] out;
        logic [9:0] oe_n;
        logic [3:0] stat;
        logic ready;
        logic fail;
    } sps_host_t;

endpackage

// File: logic/sps_link_if.sv
`include "sps_regs.svh"

interface sps_link_if;

    // Device pads
    logic [`SPS_NPIN-1:0] dev_out;
    logic [`SPS_NPIN-1:0] dev_oe_n;
    logic [`SPS_NPIN-1:0] dev_pu;
    logic [`SPS_NPIN-1:0] dev_pd;
    // Host pads
    logic [`SPS_NPIN-1:0] host_out;
    logic [`SPS_NPIN-1:0] host_oe_n;
    // Supply and clock status from host side
    logic [`SPS_NSTAT-1:0] stat;
    // Resolved pin levels
    logic [`SPS_NPIN-1:0] level;

    // ****************************************************************
    // Wire resolution
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < `SPS_NPIN; i++) begin : g_pin
            // Driver first, then pull; floating reads high only where pulled up
            assign level[i] = !dev_oe_n[i] ? dev_out[i] :
                              !host_oe_n[i] ? host_out[i] :
                              dev_pu[i];
        end
    endgenerate

    modport device (
        output dev_out,
        output dev_oe_n,
        output dev_pu,
        output dev_pd,
        input stat,
        input level
    );

    modport host (
        output host_out,
        output host_oe_n,
        output stat,
        input level
    );

endinterface

// File: logic/sps_device.sv
`include "sps_regs.svh"

module sps_device #(
    parameter int BOOT_CYCLES = `SPS_MS_TO_CYC(`SPS_T_SLOW_CLK_MS)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    sps_link_if.device link,
    input wire logic user_tx,
    input wire logic user_debug,
    output sps_pkg::sps_dev_state_t power_state,
    output logic user_rx,
    output logic user_grant_n,
    output logic user_audio_clk,
    output logic user_audio_fsync,
    output logic user_audio_in
);

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int CW = sps_pkg::CNT_W;
    localparam logic [CW-1:0] BOOT_LAST = CW'(BOOT_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam int PDR = `SPS_NSTAT + `SPS_PIN_PDR;
    localparam int SIN = `SPS_NSTAT + `SPS_PIN_SIN;
    localparam int FGNT = `SPS_NSTAT + `SPS_PIN_FGNT;
    localparam int ACLK = `SPS_NSTAT + `SPS_PIN_ACLK;
    localparam int AFS = `SPS_NSTAT + `SPS_PIN_AFS;
    localparam int AIN = `SPS_NSTAT + `SPS_PIN_AIN;

    // Reset state: shutdown pads, nothing driven
    localparam sps_pkg::sps_dev_t DEV_RST = '{
        st: sps_pkg::SPS_DEV_SHUT,
        cnt: '0,
        s1: {`SPS_PU_SHUT, {`SPS_NSTAT{1'b0}}}, // Idle pin levels, no false grant
        s2: {`SPS_PU_SHUT, {`SPS_NSTAT{1'b0}}},
        out: '0,
        oe_n: ~`SPS_DRV_NONE,
        pu: `SPS_PU_SHUT,
        pd: `SPS_PD_SHUT
    };

    sps_pkg::sps_dev_t dev_reg;
    sps_pkg::sps_dev_t dev_next;
    logic run_ok;
    logic clocks_ok;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Pad set for shutdown and power-up
    function automatic sps_pkg::sps_dev_t pads_shut(input sps_pkg::sps_dev_t d);
        sps_pkg::sps_dev_t r;
        r = d;
        r.out = '0;
        r.oe_n = ~`SPS_DRV_NONE;
        r.pu = `SPS_PU_SHUT;
        r.pd = `SPS_PD_SHUT;
        return r;
    endfunction

    // Pad set for active mode with given drive levels
    function automatic sps_pkg::sps_dev_t pads_act(input sps_pkg::sps_dev_t d, input logic sout,
                                                   input logic freq, input logic dbg);
        sps_pkg::sps_dev_t r;
        r = d;
        r.out = '0;
        r.out[`SPS_PIN_SOUT] = sout;
        r.out[`SPS_PIN_FREQ] = freq;
        r.out[`SPS_PIN_DBG] = dbg;
        r.oe_n = ~`SPS_DRV_ACT;
        r.pu = `SPS_PU_ACT;
        r.pd = `SPS_PD_ACT;
        return r;
    endfunction

    // ****************************************************************
    // Qualifiers from synchronised inputs
    // ****************************************************************

    // Both supplies up and request released
    assign run_ok = dev_reg.s2[PDR] && dev_reg.s2[`SPS_ST_MAIN] && dev_reg.s2[`SPS_ST_IO];

    // Reference clocks reported stable
    assign clocks_ok = dev_reg.s2[`SPS_ST_FAST] && dev_reg.s2[`SPS_ST_SLOW];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        dev_next = dev_reg;
        // Two-stage synchronisers for all link inputs
        dev_next.s1 = {link.level, link.stat};
        dev_next.s2 = dev_reg.s1;
        if (!run_ok) begin
            // Request low or supply missing: hold in reset, pads parked
            dev_next = pads_shut(dev_next);
            dev_next.st = sps_pkg::SPS_DEV_SHUT;
            dev_next.cnt = CNT_ZERO;
        end else begin
            case (dev_reg.st)
                sps_pkg::SPS_DEV_SHUT: begin
                    // Request released: start internal power-up
                    dev_next = pads_shut(dev_next);
                    dev_next.st = sps_pkg::SPS_DEV_BOOT;
                    dev_next.cnt = CNT_ZERO;
                end
                sps_pkg::SPS_DEV_BOOT: begin
                    // Pins stay parked until boot completes
                    dev_next = pads_shut(dev_next);
                    if (clocks_ok) begin
                        if (dev_reg.cnt == BOOT_LAST) begin
                            dev_next.st = sps_pkg::SPS_DEV_INIT;
                            dev_next.cnt = CNT_ZERO;
                        end else begin
                            dev_next.cnt = dev_reg.cnt + CNT_ONE;
                        end
                    end
                end
                sps_pkg::SPS_DEV_INIT: begin
                    // Default active pads, flow request still high
                    dev_next = pads_act(dev_next, 1'b1, 1'b1, 1'b1);
                    dev_next.st = sps_pkg::SPS_DEV_READY;
                end
                sps_pkg::SPS_DEV_READY: begin
                    // Power-up done: flow request low
                    dev_next = pads_act(dev_next, user_tx, 1'b0, user_debug);
                end
                default: begin
                    dev_next = pads_shut(dev_next);
                    dev_next.st = sps_pkg::SPS_DEV_SHUT;
                    dev_next.cnt = CNT_ZERO;
                end
            endcase
        end
        // Request input always pulled down
        dev_next.pd[`SPS_PIN_PDR] = 1'b1;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dev_reg <= DEV_RST;
        end else if (ce) begin
            dev_reg <= dev_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Pads to the link
    assign link.dev_out = dev_reg.out;
    assign link.dev_oe_n = dev_reg.oe_n;
    assign link.dev_pu = dev_reg.pu;
    assign link.dev_pd = dev_reg.pd;

    // User side, straight from flops
    assign power_state = dev_reg.st;
    assign user_rx = dev_reg.s2[SIN];
    assign user_grant_n = dev_reg.s2[FGNT];
    assign user_audio_clk = dev_reg.s2[ACLK];
    assign user_audio_fsync = dev_reg.s2[AFS];
    assign user_audio_in = dev_reg.s2[AIN];

endmodule

// File: tb/sps_link_monitor.sv
`include "sps_regs.svh"

module sps_link_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [9:0] dev_out,
    input wire logic [9:0] dev_oe_n,
    input wire logic [9:0] dev_pu,
    input wire logic [9:0] dev_pd,
    input wire logic [9:0] host_out,
    input wire logic [9:0] host_oe_n,
    input wire logic [3:0] stat,
    input wire logic [9:0] level
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int READY_BOUND = 20;
    logic [7:0] low_cnt;

    // ****************************************************************
    // Helper logic
    // ****************************************************************
    // Counts cycles with the request pin low
    always_ff @(posedge clk) begin
        if (sys_rst || level[9]) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_PDR_PULLDOWN:
        assert property (dev_pd[9]) else $error("request pin pull-down off");
    AST_SHUT_HIZ:
        assert property ((!level[9]) [*5] |-> dev_oe_n == 10'h3FF) else $error("pads driven in shutdown");
    AST_SHUT_PULLS:
        assert property ((!level[9]) [*5] |-> dev_pu == `SPS_PU_SHUT && dev_pd == `SPS_PD_SHUT)
        else $error("wrong pulls in shutdown");
    AST_DRIVE_NEEDS_POWER:
        assert property (dev_oe_n != 10'h3FF |-> $past(level[9], 3) && $past(stat[1:0], 3) == 2'b11)
        else $error("pads driven without power");
    AST_INIT_DEFAULT:
        assert property ($fell(dev_oe_n[2]) |-> dev_oe_n == 10'h2F9 && dev_out[2] && dev_out[1]
            && dev_pu == `SPS_PU_ACT && dev_pd == `SPS_PD_ACT) else $error("wrong default active pads");
    AST_READY_AFTER_INIT:
        assert property ($fell(dev_oe_n[2]) |=> !dev_out[2]) else $error("flow request not lowered");
    AST_READY_BOUND:
        assert property ($rose(level[9]) |-> ##[1:READY_BOUND] (!level[2] || !level[9]))
        else $error("flow request late");
    AST_CLOCKS_AT_RELEASE:
        assert property ($rose(level[9]) |-> ##[0:READY_BOUND] stat[3:2] == 2'b11)
        else $error("clocks not reported stable after release");
    AST_HOLD_MIN:
        assert property ($rose(level[9]) |-> low_cnt >= 8'h08) else $error("request low too short");
    AST_HOST_OFF_PINS:
        assert property (!stat[1] |-> host_oe_n == 10'h1FF && !host_out[9]) else $error("host drives unpowered pins");
    AST_RELEASE_SUPPLIED:
        assert property (level[9] |-> stat[1:0] == 2'b11) else $error("request released without supplies");
    AST_NO_TRAFFIC_EARLY:
        assert property (!host_oe_n[0] && !host_out[0] |-> !level[2]) else $error("host traffic before ready");

endmodule

// File: tb/shutdown_powerup_sequencer_test.sv
`include "sps_regs.svh"

module shutdown_powerup_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic dev_ce = 1'b1;
    logic power_on = 1'b0;
    logic d_tx = 1'b0;
    logic d_dbg = 1'b0;
    logic h_tx = 1'b0;
    logic h_gnt_n = 1'b0;
    logic h_aclk = 1'b0;
    logic h_afs = 1'b0;
    logic h_ain = 1'b0;
    sps_pkg::sps_dev_state_t power_state;
    logic d_rx, d_gnt_n, d_aclk, d_afs, d_ain;
    logic host_ready, host_fail, h_rx, dev_flow_req;
    logic mon_rst;
    logic tv;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    int n;

    // ****************************************************************
    // Design and monitor
    // ****************************************************************
    sps_link_if link ();

    sps_device #(.BOOT_CYCLES(4)) u_sps_device (.clk(clk), .sys_rst(sys_rst), .ce(dev_ce), .link(link),
        .user_tx(d_tx), .user_debug(d_dbg), .power_state(power_state), .user_rx(d_rx),
        .user_grant_n(d_gnt_n), .user_audio_clk(d_aclk), .user_audio_fsync(d_afs), .user_audio_in(d_ain));

    sps_host #(.HOLD_CYCLES(8), .READY_CYCLES(64)) u_sps_host (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .link(link), .power_on(power_on), .user_tx(h_tx), .user_grant_n(h_gnt_n), .user_audio_clk(h_aclk),
        .user_audio_fsync(h_afs), .user_audio_in(h_ain), .host_ready(host_ready), .host_fail(host_fail),
        .user_rx(h_rx), .dev_flow_req(dev_flow_req));

    // Monitor also idles while the device is held
    assign mon_rst = sys_rst | ~dev_ce;

    sps_link_monitor u_sps_link_monitor (.clk(clk), .sys_rst(mon_rst), .dev_out(link.dev_out),
        .dev_oe_n(link.dev_oe_n), .dev_pu(link.dev_pu), .dev_pd(link.dev_pd), .host_out(link.host_out),
        .host_oe_n(link.host_oe_n), .stat(link.stat), .level(link.level));

    // ****************************************************************
    // Clock, timeout and helpers
    // ****************************************************************
    // Clock at 10 MHz
    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            $display("FAIL timeout reached");
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clk);
    endtask

    function automatic logic pick(input int s);
        if (s < 10) return link.level[s];
        if (s == 10) return host_ready;
        return host_fail;
    endfunction

    // Waits at falling edges for a pin or flag, bounded
    task automatic wait_for(input int s, input logic v, output int k);
        k = 0;
        while (pick(s) !== v && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (k == 300) begin
            error_cnt++;
            $display("FAIL wait on %0d expected %0b seen %0b", s, v, pick(s));
        end
    endtask

    task automatic set_users(input logic v);
        @(posedge clk);
        d_tx <= v;
        d_dbg <= v;
        h_tx <= v;
        h_gnt_n <= v;
        h_aclk <= v;
        h_afs <= v;
        h_ain <= v;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // Shutdown pads; device ignores user data
        set_users(1'b0);
        cycles(4);
        check("dev_oe_n", link.dev_oe_n, 10'h3FF);
        check("dev_pu", link.dev_pu, `SPS_PU_SHUT);
        check("dev_pd", link.dev_pd, `SPS_PD_SHUT);
        check("request pin", link.level[9], 1'b0);
        check("host holds request", link.host_oe_n[9], 1'b0);
        check("serial out idle", link.level[1], 1'b1);
        check("state", power_state, sps_pkg::SPS_DEV_SHUT);
        $display("test reset_state done");
        // Power-up timing
        @(posedge clk);
        power_on <= 1'b1;
        wait_for(9, 1'b1, n);
        check("hold long", n >= 8, 1'b1);
        check("supplies", link.stat[1:0], 2'b11);
        check("clocks", link.stat[3:2], 2'b11);
        cycles(5);
        check("boot pads", link.dev_oe_n, 10'h3FF);
        check("boot state", power_state, sps_pkg::SPS_DEV_BOOT);
        wait_for(2, 1'b0, n);
        check("ready delay", n, 4);
        wait_for(10, 1'b1, n);
        check("host delay", n, 3);
        check("flow seen", dev_flow_req, 1'b0);
        check("no fail", host_fail, 1'b0);
        check("ready state", power_state, sps_pkg::SPS_DEV_READY);
        check("active pu", link.dev_pu, `SPS_PU_ACT);
        check("active pd", link.dev_pd, `SPS_PD_ACT);
        $display("test power_up done");
        // Data both ways in active mode
        for (int i = 0; i < 2; i++) begin
            tv = (i == 0);
            set_users(tv);
            cycles(4);
            check("serial out", h_rx, tv);
            check("debug out", link.level[8], tv);
            check("serial in", d_rx, tv);
            check("grant", d_gnt_n, tv);
            check("audio clk", d_aclk, tv);
            check("audio fsync", d_afs, tv);
            check("audio in", d_ain, tv);
        end
        $display("test active_data done");
        // Back into shutdown
        @(posedge clk);
        power_on <= 1'b0;
        cycles(6);
        check("shut oe_n", link.dev_oe_n, 10'h3FF);
        check("shut pu", link.dev_pu, `SPS_PU_SHUT);
        check("shut pd", link.dev_pd, `SPS_PD_SHUT);
        check("shut state", power_state, sps_pkg::SPS_DEV_SHUT);
        check("flow pulled up", link.level[2], 1'b1);
        check("host pins off", link.host_oe_n, 10'h1FF);
        check("ready off", host_ready, 1'b0);
        $display("test shutdown done");
        // Silent device: host gives up
        @(posedge clk);
        power_on <= 1'b1;
        dev_ce <= 1'b0;
        wait_for(11, 1'b1, n);
        check("fail delay", n >= 72, 1'b1);
        check("fail request", link.level[9], 1'b0);
        check("fail ready", host_ready, 1'b0);
        @(posedge clk);
        power_on <= 1'b0;
        dev_ce <= 1'b1;
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        $display("test no_answer done");
        // Reset in mid boot, then recovery
        @(posedge clk);
        power_on <= 1'b1;
        wait_for(9, 1'b1, n);
        cycles(5);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        cycles(1);
        check("reset state", power_state, sps_pkg::SPS_DEV_SHUT);
        check("reset pads", link.dev_oe_n, 10'h3FF);
        wait_for(10, 1'b1, n);
        check("recovered", host_ready, 1'b1);
        $display("test mid_reset done");
        finish_test();
    end

endmodule
